// ==== hw/cpne_pkg.sv ====
// constants, types and timing counts of the pdo and nmt engine
// assumes a 125 mhz device clock and standard 11-bit can identifiers
package cpne_pkg;
	// ****************************************************************
	// frame layout
	// ****************************************************************
	localparam int PAYLOAD_BYTES = 8;
	localparam int PAYLOAD_BITS = PAYLOAD_BYTES * 8;
	localparam int MAP_ENTRIES = 8;
	localparam logic [10:0] NMT_COB_ID = 11'h000;
	localparam logic [10:0] SYNC_COB_ID = 11'h080;
	localparam logic [7:0] NMT_CMD_START = 8'h01;
	localparam logic [7:0] NMT_CMD_PREOP = 8'h80;
	localparam logic [7:0] NMT_ALL_NODES = 8'h00;
	localparam logic [3:0] NMT_MIN_DLC = 4'h2;
	// ****************************************************************
	// transmission types
	// ****************************************************************
	localparam logic [7:0] TT_SYNC_MIN = 8'h01;
	localparam logic [7:0] TT_SYNC_MAX = 8'hf0;
	localparam logic [7:0] TT_RTR_ONLY = 8'hfd;
	localparam logic [7:0] TT_ASYNC = 8'hff;
	// ****************************************************************
	// default identifiers
	// ****************************************************************
	localparam logic [10:0] TPDO_BASE = 11'h180;
	localparam logic [10:0] RPDO_BASE = 11'h200;
	localparam logic [10:0] PDO_STEP = 11'h100;
	// ****************************************************************
	// mapping entry fields
	// ****************************************************************
	localparam int MAP_IDX_LSB = 16;
	localparam int MAP_SUB_LSB = 8;
	localparam int MAP_LEN_LSB = 0;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 8000;
	localparam int INHIBIT_UNIT_US = 100;
	localparam int INHIBIT_TICK_CYCLES = (INHIBIT_UNIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		NMT_INIT,
		NMT_PREOP,
		NMT_OPER
	} cpne_nmt_t;
endpackage

// ==== hw/cpne_map_table.sv ====
// one pdo mapping table: mapped-object count plus the mapping entries
// assumes writes arrive as single-cycle strobes from the configuring side
`timescale 1ns/1ps
module cpne_map_table #(
	parameter int ENTRIES = cpne_pkg::MAP_ENTRIES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration write
	input wire logic wrEn,
	input wire logic [3:0] wrSub,
	input wire logic [31:0] wrData,
	// decoded mapping
	output logic [3:0] count,
	output logic enabled,
	output logic [8*ENTRIES-1:0] lens,
	output logic [16*ENTRIES-1:0] objIndex,
	output logic [8*ENTRIES-1:0] objSub,
	output logic [7:0] totalBits
);
	if (ENTRIES < 1 || ENTRIES > 8) begin : g_bad
		$error("cpne_map_table: ENTRIES must be 1 to 8");
	end

	typedef struct packed {
		logic [3:0] count;
		logic [ENTRIES-1:0][31:0] entry;
	} cpne_map_t;

	cpne_map_t s_r;
	cpne_map_t s_nxt;

	function automatic logic [11:0] sumBits(input cpne_map_t m, input logic [3:0] cnt, output logic zeroLen);
		logic [11:0] acc;
		acc = 12'h000;
		zeroLen = 1'b0;
		for (int k = 0; k < ENTRIES; k++) begin
			if (k < cnt) begin
				acc = acc + {4'h0, m.entry[k][cpne_pkg::MAP_LEN_LSB +: 8]};
				if (m.entry[k][cpne_pkg::MAP_LEN_LSB +: 8] == 8'h00) begin
					zeroLen = 1'b1;
				end
			end
		end
		return acc;
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic [11:0] reqBits;
		logic reqZero;
		logic [11:0] curBits;
		logic curZero;
		s_nxt = s_r;
		reqBits = sumBits(s_r, wrData[3:0], reqZero);
		curBits = sumBits(s_r, s_r.count, curZero);
		if (wrEn && wrSub == 4'h0) begin
			if (wrData == 32'h0000_0000) begin
				s_nxt.count = 4'h0;
			end else if (wrData <= ENTRIES && !reqZero && reqBits <= cpne_pkg::PAYLOAD_BITS) begin
				s_nxt.count = wrData[3:0];
			end
		end else if (wrEn && s_r.count == 4'h0 && wrSub <= ENTRIES) begin
			s_nxt.entry[wrSub - 4'h1] = wrData;
		end
		count = s_r.count;
		enabled = s_r.count != 4'h0;
		totalBits = curBits[7:0];
		for (int k = 0; k < ENTRIES; k++) begin
			lens[8*k +: 8] = s_r.entry[k][cpne_pkg::MAP_LEN_LSB +: 8];
			objSub[8*k +: 8] = s_r.entry[k][cpne_pkg::MAP_SUB_LSB +: 8];
			objIndex[16*k +: 16] = s_r.entry[k][cpne_pkg::MAP_IDX_LSB +: 16];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	a_count_zero: assert property (@(posedge clk) disable iff (!rst_n)
		wrEn && wrSub == 4'h0 && wrData == 32'h0000_0000 |=> !enabled && count == 4'h0)
		else $error("zero count did not disable the pdo");
	a_count_set: assert property (@(posedge clk) disable iff (!rst_n)
		wrEn && wrSub == 4'h0 && wrData != 32'h0000_0000 && enabled |=> enabled)
		else $error("nonzero count write disabled the pdo");
	a_count_take: assert property (@(posedge clk) disable iff (!rst_n)
		wrEn && wrSub == 4'h0 && wrData != 32'h0000_0000
		|=> count <= ENTRIES && (count == $past(wrData[3:0]) || count == $past(count)))
		else $error("count write neither taken at once nor ignored");
endmodule

// ==== hw/cpne_engine.sv ====
// pdo and nmt slave engine: one transmit pdo and one receive pdo
// assumes a can controller hands over received frames as one-cycle strobes
// and takes the transmit frame through a valid/ready handshake
//
// Behaviour
// - a pdo payload is at most eight bytes, packed from mapped objects.
// - pdo identifiers are unique and produced by one node only; the engine lets transmit and receive take the same identifier.
// - after reset the node enters pre-operational by itself.
// - in pre-operational no pdo is sent or acted upon; a frame raised in operational stays on txValid until taken.
// - nmt command 01 on identifier 0 starts the addressed node or all.
// - nmt command 80 on identifier 0 returns addressed node to pre-operational.
// - with type fd or ff, a remote frame on the transmit identifier makes the producer send it.
// - with event transmission a change of a mapped object sends the pdo.
// - event sends keep at least the inhibit time apart, in 100 us steps.
// - cyclic synchronous mode waits for sync, then sends sampled values.
// - synchronous types 1 to 240 all behave as one sync per send.
// - mapping fixes the order and bit length of each packed object.
// - transmit identifier defaults to 0x180-based offset plus node id.
// - receive identifier defaults to 0x200-based offset plus node id.
// - type 01 transmit samples and sends after each sync.
// - type 01 receive data is held until the next sync.
// - type fd transmit is sampled and sent only on remote request.
// - type ff transmit sends on remote request or on value change.
// - type ff receive data goes to the application at once.
// - a zero mapped-object count disables the pdo for remapping.
// - a nonzero count of at most eight entries, none of zero length, totalling at most 64 bits, re-enables the pdo immediately.
`timescale 1ns/1ps
module cpne_engine #(
	parameter int TX_PDO_NUM = 1,
	parameter int RX_PDO_NUM = 1,
	parameter int TICK_CYCLES = cpne_pkg::INHIBIT_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// node identity
	input wire logic [6:0] nodeId,
	// received frames
	input wire logic rxValid,
	input wire logic [10:0] rxId,
	input wire logic rxRtr,
	input wire logic [3:0] rxDlc,
	input wire logic [63:0] rxData,
	// transmit frame
	output logic txValid,
	input wire logic txReady,
	output logic [10:0] txId,
	output logic [3:0] txDlc,
	output logic [63:0] txData,
	// communication parameters
	input wire logic [7:0] txType,
	input wire logic [7:0] rxType,
	input wire logic [15:0] inhibitTime,
	input wire logic txCobWr,
	input wire logic rxCobWr,
	input wire logic cobRestore,
	input wire logic [10:0] cobWrData,
	// mapping writes
	input wire logic mapWr,
	input wire logic mapSelRx,
	input wire logic [3:0] mapSub,
	input wire logic [31:0] mapData,
	// application objects
	input wire logic [255:0] txObjVals,
	output logic [255:0] rxObjVals,
	output logic rxObjStrobe,
	// status
	output cpne_pkg::cpne_nmt_t nmtState,
	output logic txPdoEnabled,
	output logic rxPdoEnabled,
	output logic [10:0] txCobId,
	output logic [10:0] rxCobId
);
	if (TX_PDO_NUM < 1 || TX_PDO_NUM > 4 || RX_PDO_NUM < 1 || RX_PDO_NUM > 4) begin : g_bad_num
		$error("cpne_engine: pdo numbers must be 1 to 4");
	end
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
		$error("cpne_engine: TICK_CYCLES must fit 16 bits");
	end

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	typedef struct packed {
		cpne_pkg::cpne_nmt_t nmt;
		logic txValid;
		logic [10:0] txId;
		logic [3:0] txDlc;
		logic [63:0] txData;
		logic [63:0] lastSent;
		logic rtrPend;
		logic syncPend;
		logic [15:0] tickCnt;
		logic [15:0] inhCnt;
		logic txCobCustom;
		logic [10:0] txCob;
		logic rxCobCustom;
		logic [10:0] rxCob;
		logic [63:0] rxHeld;
		logic rxHeldValid;
		logic [255:0] rxObj;
		logic rxStrobe;
	} cpne_state_t;

	cpne_state_t s_r;
	cpne_state_t s_nxt;

	logic [3:0] txCount;
	logic [3:0] rxCount;
	logic [63:0] txLens;
	logic [63:0] rxLens;
	logic [7:0] txBits;
	logic [7:0] rxBits;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [63:0] packObjs(input logic [255:0] vals, input logic [63:0] lens, input logic [3:0] cnt);
		logic [63:0] res;
		int pos;
		res = 64'h0;
		pos = 0;
		for (int k = 0; k < 8; k++) begin
			if (k < cnt) begin
				for (int b = 0; b < 32; b++) begin
					if (b < lens[8*k +: 8] && pos + b < 64) begin
						res[pos + b] = vals[32*k + b];
					end
				end
				pos = pos + lens[8*k +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [255:0] unpackObjs(input logic [63:0] pay, input logic [63:0] lens, input logic [3:0] cnt);
		logic [255:0] res;
		int pos;
		res = 256'h0;
		pos = 0;
		for (int k = 0; k < 8; k++) begin
			if (k < cnt) begin
				for (int b = 0; b < 32; b++) begin
					if (b < lens[8*k +: 8] && pos + b < 64) begin
						res[32*k + b] = pay[pos + b];
					end
				end
				pos = pos + lens[8*k +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [10:0] cobDefault(input logic [10:0] base, input int num, input logic [6:0] node);
		return base + 11'(num - 1) * cpne_pkg::PDO_STEP + {4'h0, node};
	endfunction

	function automatic logic isSyncType(input logic [7:0] tt);
		return tt >= cpne_pkg::TT_SYNC_MIN && tt <= cpne_pkg::TT_SYNC_MAX;
	endfunction

	// ****************************************************************
	// mapping tables
	// ****************************************************************
	cpne_map_table #(.ENTRIES(8)) u_txMap (
		.clk(clk),
		.rst_n(rst_n),
		.wrEn(mapWr && !mapSelRx),
		.wrSub(mapSub),
		.wrData(mapData),
		.count(txCount),
		.enabled(txPdoEnabled),
		.lens(txLens),
		.objIndex(),
		.objSub(),
		.totalBits(txBits)
	);

	cpne_map_table #(.ENTRIES(8)) u_rxMap (
		.clk(clk),
		.rst_n(rst_n),
		.wrEn(mapWr && mapSelRx),
		.wrSub(mapSub),
		.wrData(mapData),
		.count(rxCount),
		.enabled(rxPdoEnabled),
		.lens(rxLens),
		.objIndex(),
		.objSub(),
		.totalBits(rxBits)
	);

	// ****************************************************************
	// decode of the incoming frame
	// ****************************************************************
	logic nmtHit;
	logic isStart;
	logic isPreop;
	logic isSync;
	logic isTxRtr;
	logic isRxPdo;
	logic oper;
	logic [63:0] txSample;

	always_comb begin
		txCobId = s_r.txCobCustom ? s_r.txCob : cobDefault(cpne_pkg::TPDO_BASE, TX_PDO_NUM, nodeId);
		rxCobId = s_r.rxCobCustom ? s_r.rxCob : cobDefault(cpne_pkg::RPDO_BASE, RX_PDO_NUM, nodeId);
		oper = s_r.nmt == cpne_pkg::NMT_OPER;
		nmtHit = rxValid && !rxRtr && rxId == cpne_pkg::NMT_COB_ID && rxDlc >= cpne_pkg::NMT_MIN_DLC
			&& (rxData[15:8] == cpne_pkg::NMT_ALL_NODES || rxData[15:8] == {1'b0, nodeId});
		isStart = nmtHit && rxData[7:0] == cpne_pkg::NMT_CMD_START;
		isPreop = nmtHit && rxData[7:0] == cpne_pkg::NMT_CMD_PREOP;
		isSync = rxValid && !rxRtr && rxId == cpne_pkg::SYNC_COB_ID;
		isTxRtr = rxValid && rxRtr && rxId == txCobId;
		isRxPdo = rxValid && !rxRtr && rxId == rxCobId && oper && rxPdoEnabled;
		txSample = packObjs(txObjVals, txLens, txCount);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic evtDue;
		logic sendNow;
		s_nxt = s_r;
		s_nxt.rxStrobe = 1'b0;
		evtDue = txType == cpne_pkg::TT_ASYNC && txSample != s_r.lastSent && s_r.inhCnt == 16'h0000;
		sendNow = oper && txPdoEnabled && !s_r.txValid && (s_r.rtrPend || s_r.syncPend || evtDue);
		// network management
		case (s_r.nmt)
			cpne_pkg::NMT_INIT: s_nxt.nmt = cpne_pkg::NMT_PREOP;
			cpne_pkg::NMT_PREOP: begin
				if (isStart) begin
					s_nxt.nmt = cpne_pkg::NMT_OPER;
				end
			end
			cpne_pkg::NMT_OPER: begin
				if (isPreop) begin
					s_nxt.nmt = cpne_pkg::NMT_PREOP;
				end
			end
			default: s_nxt.nmt = cpne_pkg::NMT_PREOP;
		endcase
		// identifiers
		if (cobRestore) begin
			s_nxt.txCobCustom = 1'b0;
			s_nxt.rxCobCustom = 1'b0;
		end else begin
			if (txCobWr && cobWrData != cpne_pkg::NMT_COB_ID && cobWrData != cpne_pkg::SYNC_COB_ID) begin
				s_nxt.txCobCustom = 1'b1;
				s_nxt.txCob = cobWrData;
			end
			if (rxCobWr && cobWrData != cpne_pkg::NMT_COB_ID && cobWrData != cpne_pkg::SYNC_COB_ID) begin
				s_nxt.rxCobCustom = 1'b1;
				s_nxt.rxCob = cobWrData;
			end
		end
		// inhibit time base
		if (s_r.tickCnt == TICK_LAST) begin
			s_nxt.tickCnt = 16'h0000;
			if (s_r.inhCnt != 16'h0000) begin
				s_nxt.inhCnt = s_r.inhCnt - 16'h0001;
			end
		end else begin
			s_nxt.tickCnt = s_r.tickCnt + 16'h0001;
		end
		// transmit triggers
		if (oper && (txType == cpne_pkg::TT_RTR_ONLY || txType == cpne_pkg::TT_ASYNC) && isTxRtr) begin
			s_nxt.rtrPend = 1'b1;
		end
		if (oper && isSyncType(txType) && isSync) begin
			s_nxt.syncPend = 1'b1;
		end
		if (s_r.txValid && txReady) begin
			s_nxt.txValid = 1'b0;
		end
		if (sendNow) begin
			s_nxt.txValid = 1'b1;
			s_nxt.txId = txCobId;
			s_nxt.txData = txSample;
			s_nxt.txDlc = 4'((txBits + 8'h07) >> 3);
			s_nxt.lastSent = txSample;
			s_nxt.rtrPend = 1'b0;
			s_nxt.syncPend = 1'b0;
			if (txType == cpne_pkg::TT_ASYNC) begin
				s_nxt.inhCnt = inhibitTime;
				s_nxt.tickCnt = 16'h0000;
			end
		end
		if (!oper || !txPdoEnabled) begin
			s_nxt.rtrPend = 1'b0;
			s_nxt.syncPend = 1'b0;
		end
		// receive side
		if (isRxPdo && rxType == cpne_pkg::TT_ASYNC) begin
			s_nxt.rxObj = unpackObjs(rxData, rxLens, rxCount);
			s_nxt.rxStrobe = 1'b1;
		end else if (isRxPdo && isSyncType(rxType)) begin
			s_nxt.rxHeld = rxData;
			s_nxt.rxHeldValid = 1'b1;
		end
		if (isSync && s_r.rxHeldValid && oper && rxPdoEnabled) begin
			s_nxt.rxObj = unpackObjs(s_r.rxHeld, rxLens, rxCount);
			s_nxt.rxStrobe = 1'b1;
			s_nxt.rxHeldValid = 1'b0;
		end
		if (!oper) begin
			s_nxt.rxHeldValid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign txValid = s_r.txValid;
	assign txId = s_r.txId;
	assign txDlc = s_r.txDlc;
	assign txData = s_r.txData;
	assign rxObjVals = s_r.rxObj;
	assign rxObjStrobe = s_r.rxStrobe;
	assign nmtState = s_r.nmt;

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_boot_preop: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.nmt == cpne_pkg::NMT_INIT |=> s_r.nmt == cpne_pkg::NMT_PREOP)
		else $error("node did not enter pre-operational after init");
	a_preop_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.nmt != cpne_pkg::NMT_OPER && !txValid |=> !txValid && !(rxObjStrobe && !$past(isSync)))
		else $error("pdo traffic outside operational");
	a_nmt_start: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.nmt == cpne_pkg::NMT_PREOP && isStart |=> s_r.nmt == cpne_pkg::NMT_OPER)
		else $error("start command ignored");
	a_nmt_preop: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.nmt == cpne_pkg::NMT_OPER && isPreop |=> s_r.nmt == cpne_pkg::NMT_PREOP)
		else $error("enter pre-operational command ignored");
	a_rtr_answer: assert property (@(posedge clk) disable iff (!rst_n)
		oper && !isPreop && txPdoEnabled && !txValid && txType == cpne_pkg::TT_RTR_ONLY && isTxRtr
		&& !(mapWr && !mapSelRx) |=> ##1 txValid && txId == txCobId)
		else $error("remote request not answered");
	a_inhibit_gap: assert property (@(posedge clk) disable iff (!rst_n)
		txValid && !$past(txValid) && !$past(s_r.rtrPend) && !$past(s_r.syncPend) |-> $past(s_r.inhCnt) == 16'h0000)
		else $error("event pdo sent inside inhibit time");
	a_sync_send: assert property (@(posedge clk) disable iff (!rst_n)
		oper && !isPreop && txPdoEnabled && !txValid && txType == cpne_pkg::TT_SYNC_MIN && isSync
		&& !(mapWr && !mapSelRx) |=> ##1 txValid)
		else $error("sync did not trigger transmit pdo");
	a_rx_held: assert property (@(posedge clk) disable iff (!rst_n)
		isRxPdo && isSyncType(rxType) |=> !rxObjStrobe)
		else $error("synchronous receive data delivered before sync");
	a_rx_direct: assert property (@(posedge clk) disable iff (!rst_n)
		isRxPdo && rxType == cpne_pkg::TT_ASYNC |=> rxObjStrobe)
		else $error("asynchronous receive data not delivered");
	a_dlc_limit: assert property (@(posedge clk) disable iff (!rst_n)
		txValid |-> txDlc <= 4'(cpne_pkg::PAYLOAD_BYTES))
		else $error("pdo payload above eight bytes");
endmodule

// ==== tb/cpne_can_partner.sv ====
// far-side model: can controller and bus taking transmit frames
// assumes the engine offers frames through a valid/ready handshake on clk
`timescale 1ns/1ps
module cpne_can_partner (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// stall request from the bench
	input wire logic hold,
	// transmit frame
	input wire logic txValid,
	input wire logic [3:0] txDlc,
	output logic txReady,
	// tallies
	output logic [7:0] sent,
	output logic [7:0] bad
);
	// ****************************************************************
	// frame intake
	// ****************************************************************
	assign txReady = rst_n && !hold;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sent <= 8'h0;
			bad <= 8'h0;
		end else if (txValid && txReady) begin
			sent <= sent + 8'h1;
			// more than eight payload bytes is no legal frame
			if (txDlc > 4'h8) begin
				bad <= bad + 8'h1;
			end
		end
	end
endmodule

// ==== tb/canopen_pdo_nmt_engine_tb.sv ====
// bench of the pdo and nmt engine: boot and start checks, table of trigger cases, then hand tests
// assumes one pdo each way, node 5 and a short inhibit tick
`timescale 1ns/1ps
module canopen_pdo_nmt_engine_tb;
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int TICK = 4;
	logic clk, rst_n, rxValid, rxRtr, txValid, txReady, txCobWr, rxCobWr, cobRestore;
	logic mapWr, mapSelRx, hold, rxObjStrobe, txPdoEnabled, rxPdoEnabled, seen;
	logic [6:0] nodeId;
	logic [10:0] rxId, txId, cobWrData, txCobId, rxCobId;
	logic [3:0] rxDlc, txDlc, mapSub;
	logic [63:0] rxData, txData, expTx;
	logic [7:0] txType, rxType, sent, bad, expSent;
	logic [15:0] inhibitTime;
	logic [31:0] mapData;
	logic [255:0] txObjVals, rxObjVals;
	cpne_pkg::cpne_nmt_t nmtState;
	int err_count, checked, n;
	typedef struct packed {logic [7:0] tt; logic rtr; logic want;} cpne_row_t;
	cpne_row_t rows [7] = '{
		'{8'hfd, 1'h1, 1'h1},
		'{8'hfd, 1'h0, 1'h0},
		'{8'h01, 1'h0, 1'h1},
		'{8'hf0, 1'h0, 1'h1},
		'{8'hff, 1'h1, 1'h1},
		'{8'hff, 1'h0, 1'h0},
		'{8'h00, 1'h0, 1'h0}
	};
	cpne_engine #(.TICK_CYCLES(TICK)) cpne_engine_i (.clk, .rst_n, .nodeId, .rxValid, .rxId, .rxRtr,
		.rxDlc, .rxData, .txValid, .txReady, .txId, .txDlc, .txData, .txType, .rxType, .inhibitTime,
		.txCobWr, .rxCobWr, .cobRestore, .cobWrData, .mapWr, .mapSelRx, .mapSub, .mapData, .txObjVals,
		.rxObjVals, .rxObjStrobe, .nmtState, .txPdoEnabled, .rxPdoEnabled, .txCobId, .rxCobId);
	cpne_can_partner cpne_can_partner_i (.clk, .rst_n, .hold, .txValid, .txDlc, .txReady, .sent, .bad);
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'h1) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic frame(input logic [10:0] id, input logic rtr, input logic [63:0] d);
		rxId = id;
		rxRtr = rtr;
		rxData = d;
		rxValid = 1'h1;
		tick(1);
		rxValid = 1'h0;
	endtask
	task automatic nmt(input logic [7:0] cmd, input logic [7:0] node);
		frame(11'h000, 1'h0, {48'h0, node, cmd});
		tick(1);
	endtask
	task automatic mapWrite(input logic sel, input logic [3:0] sub, input logic [31:0] d);
		mapSelRx = sel;
		mapSub = sub;
		mapData = d;
		mapWr = 1'h1;
		tick(1);
		mapWr = 1'h0;
		tick(1);
	endtask
	task automatic expectTx(input logic want, input logic [63:0] d);
		seen = 1'h0;
		for (int i = 0; i < 8 && !seen; i++) begin
			tick(1);
			seen = (txValid === 1'h1);
		end
		chk(seen === want, "tx presence");
		if (seen && want) begin
			chk(txId === 11'h185 && txDlc === 4'h6 && txData === d, "tx frame");
			expSent++;
			tick(2);
		end
		if (want && !seen) print_verdict();
	endtask
	task automatic waitStrobe(input logic want);
		seen = 1'h0;
		for (int i = 0; i < 4; i++) begin
			seen |= (rxObjStrobe === 1'h1);
			tick(1);
		end
		chk(seen === want, "rx strobe");
	endtask
	initial begin
		#500000;
		err_count++;
		print_verdict();
	end
	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		{rst_n, rxValid, rxRtr, txCobWr, rxCobWr, cobRestore, mapWr, mapSelRx, hold} = 9'h0;
		{rxId, cobWrData, mapSub, rxData, txType, rxType, inhibitTime, mapData} = '0;
		txObjVals = '0;
		rxDlc = 4'h8;
		nodeId = 7'h05;
		expSent = 8'h0;
		tick(10);
		chk(nmtState === cpne_pkg::NMT_INIT && txValid === 1'h0, "reset");
		rst_n = 1'h1;
		tick(2);
		chk(nmtState === cpne_pkg::NMT_PREOP, "boot");
		chk(txCobId === 11'h185 && rxCobId === 11'h205, "default ids");
		mapWrite(1'h0, 4'h1, 32'h60400010);
		mapWrite(1'h0, 4'h2, 32'h607a0020);
		mapWrite(1'h0, 4'h0, 32'h2);
		mapWrite(1'h1, 4'h1, 32'h60400010);
		mapWrite(1'h1, 4'h2, 32'h20000108);
		mapWrite(1'h1, 4'h0, 32'h2);
		chk(txPdoEnabled === 1'h1 && rxPdoEnabled === 1'h1, "enable");
		txType = 8'hfd;
		txObjVals[63:0] = 64'h12345678_0000beef;
		expTx = 64'h0000_12345678_beef;
		frame(11'h185, 1'h1, 64'h0);
		expectTx(1'h0, expTx);
		nmt(8'h01, 8'h06);
		chk(nmtState === cpne_pkg::NMT_PREOP, "other node");
		nmt(8'h01, 8'h00);
		chk(nmtState === cpne_pkg::NMT_OPER, "start all");
		foreach (rows[i]) begin
			txType = rows[i].tt;
			tick(1);
			frame(rows[i].rtr ? 11'h185 : 11'h080, rows[i].rtr, 64'h0);
			expectTx(rows[i].want, expTx);
		end
		txType = 8'hff;
		inhibitTime = 16'h0002;
		tick(2);
		txObjVals[15:0] = 16'hcafe;
		expTx[15:0] = 16'hcafe;
		expectTx(1'h1, expTx);
		hold = 1'h1;
		txObjVals[15:0] = 16'h1111;
		expTx[15:0] = 16'h1111;
		n = 0;
		while (txValid !== 1'h1 && n < 40) begin
			tick(1);
			n++;
		end
		chk(n >= 6 && n <= 12, "inhibit gap");
		tick(3);
		chk(txValid === 1'h1 && txData === expTx, "stalled frame held");
		expectTx(1'h1, expTx);
		hold = 1'h0;
		tick(1);
		chk(txValid === 1'h0, "held frame taken");
		rxType = 8'hff;
		frame(11'h205, 1'h0, 64'h774321);
		waitStrobe(1'h1);
		chk(rxObjVals[15:0] === 16'h4321 && rxObjVals[39:32] === 8'h77, "rx unpack");
		rxType = 8'h01;
		frame(11'h205, 1'h0, 64'h885678);
		waitStrobe(1'h0);
		chk(rxObjVals[15:0] === 16'h4321, "rx held");
		frame(11'h080, 1'h0, 64'h0);
		waitStrobe(1'h1);
		chk(rxObjVals[15:0] === 16'h5678 && rxObjVals[39:32] === 8'h88, "rx on sync");
		nmt(8'h80, 8'h05);
		chk(nmtState === cpne_pkg::NMT_PREOP, "preop node");
		frame(11'h185, 1'h1, 64'h0);
		expectTx(1'h0, expTx);
		mapWrite(1'h0, 4'h0, 32'h0);
		chk(txPdoEnabled === 1'h0, "disable");
		mapWrite(1'h0, 4'h0, 32'h3);
		chk(txPdoEnabled === 1'h0, "count over empty entry refused");
		nmt(8'h01, 8'h05);
		chk(nmtState === cpne_pkg::NMT_OPER, "start node");
		frame(11'h185, 1'h1, 64'h0);
		expectTx(1'h0, expTx);
		nmt(8'h80, 8'h00);
		chk(nmtState === cpne_pkg::NMT_PREOP, "preop all");
		cobWrData = 11'h233;
		{txCobWr, rxCobWr} = 2'h3;
		tick(1);
		{txCobWr, rxCobWr} = 2'h0;
		tick(1);
		chk(txCobId === 11'h233, "id rewrite");
		chk(rxCobId === 11'h233, "rx id rewrite");
		cobRestore = 1'h1;
		tick(1);
		cobRestore = 1'h0;
		tick(1);
		chk(txCobId === 11'h185, "id restore");
		chk(rxCobId === 11'h205, "rx id restore");
		cobWrData = 11'h080;
		txCobWr = 1'h1;
		tick(1);
		txCobWr = 1'h0;
		tick(1);
		chk(txCobId === 11'h185, "reserved id refused");
		chk(sent === expSent && bad === 8'h0, "partner tally");
		print_verdict();
	end
endmodule
